// >>> adcfg_bank.sv
`timescale 1ns/1ps

// Behaviour
// - Gang set: all active channels use channel 1 volume; clear: all use the volume_target_at_unity input.
// - Two-bit biquad count selects 0 to 3 filters; resets to 2.
// - Soft-step disable 0 ramps gain changes; 1 applies them at once.
// - Select bit picks range enhancer at 0, gain controller at 1.
// - Enhancer threshold -12 dB at 0, -6 dB per code; 10-15 reserved; reset 7.
// - Enhancer gain limit 2 dB at 0, +2 dB per code; 13-15 reserved; reset 11.
// - Gain controller target -6 dB at 0, -2 dB per code; reset 14.
// - Gain controller limit 3 dB at 0, +3 dB per code; 14-15 reserved; reset 7.
// - Input enable: channel 1 at bit 7 to channel 8 at bit 0; reset F0.
// - Channels 5 to 8 are pulse-density microphone only; enables reset to 0.
// - Clear slot-enable bit tri-states that output slot; set bit drives it.
// - Power bit up powers enabled channels only; clear powers all down.
module adcfg_bank (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire adcfg_pkg::adcfg_req_t    req,
  output adcfg_pkg::adcfg_rsp_t         rsp,
  input  wire logic [7:0]               pdm_present,
  input  wire logic [7:0]               volume_target_at_unity,
  output adcfg_pkg::adcfg_dsp1_t        dsp_config,
  output adcfg_pkg::adcfg_enh_t         enhancer_config,
  output adcfg_pkg::adcfg_gainctl_t     gainctl_config,
  output logic [7:0]                    channel_active,
  output logic [7:0]                    slot_drive,
  output logic [7:0]                    channel_power,
  output logic                          enhancer_active,
  output logic                          gainctl_active,
  output logic [7:0]                    applied_volume,
  output logic [2:0]                    applied_volume_channel,
  output logic                          volume_settled,
  output logic                          code_reserved
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_SNAP = 2'b11
  } adcfg_vol_state_t;

  typedef struct packed {
    adcfg_pkg::adcfg_dsp1_t    dsp;
    adcfg_pkg::adcfg_enh_t     enh;
    adcfg_pkg::adcfg_gainctl_t gc;
    logic [7:0]                in_en;
    logic [7:0]                slot_en;
    logic [7:0]                pwr;
    adcfg_pkg::adcfg_rsp_t     rsp;
    logic                      rd_mem;
    logic [7:0]                ch_active;
    logic [7:0]                slot_drive;
    logic [7:0]                ch_power;
    logic                      enh_act;
    logic                      gc_act;
    adcfg_vol_state_t          vstate;
    logic [2:0]                vch;
    logic [7:0]                vcur;
    logic                      settled;
    logic                      reserved;
  } adcfg_state_t;

  adcfg_state_t st;
  adcfg_state_t next_st;

  logic       mem_wr;
  logic [2:0] mem_waddr;
  logic [2:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [7:0] mem_first;
  logic [7:0] pdm_meta;
  logic [7:0] pdm_sync;

  function automatic logic volume_hit(input logic [7:0] a, output logic [2:0] idx);
    logic [7:0] d;
    d   = a - adcfg_pkg::ADDR_CHANNEL_VOLUME;
    idx = 3'(d / 8'(adcfg_pkg::VOLUME_STRIDE));
    return (a >= adcfg_pkg::ADDR_CHANNEL_VOLUME) &&
           (d % 8'(adcfg_pkg::VOLUME_STRIDE) == 8'h00) &&
           (d / 8'(adcfg_pkg::VOLUME_STRIDE) < 8'(adcfg_pkg::NUM_CHANNELS));
  endfunction

  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt) begin
      return cur + adcfg_pkg::VOLUME_STEP;
    end else if (cur > tgt) begin
      return cur - adcfg_pkg::VOLUME_STEP;
    end
    return cur;
  endfunction

  adcfg_volume_mem u_volume_mem (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .wr    (mem_wr),
    .waddr (mem_waddr),
    .wdata (req.wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata),
    .first (mem_first)
  );

  // pdm presence comes from the pin side
  always_ff @(posedge mclk) begin
    if (rst) begin
      pdm_meta <= 8'h00;
      pdm_sync <= 8'h00;
    end else if (ce) begin
      pdm_meta <= pdm_present;
      pdm_sync <= pdm_meta;
    end
  end

  always_comb begin
    logic [2:0] widx;
    logic [2:0] ridx;
    logic       whit;
    logic       rhit;
    logic [7:0] tgt;
    widx      = 3'h0;
    ridx      = 3'h0;
    whit      = volume_hit(req.addr, widx);
    rhit      = volume_hit(req.addr, ridx);
    tgt       = 8'h00;
    next_st   = st;
    mem_wr    = req.wr && whit;
    mem_waddr = widx;
    mem_raddr = ridx;

    if (req.wr) begin
      unique case (req.addr)
        adcfg_pkg::ADDR_DSP_CONFIG_1:    next_st.dsp     = req.wdata;
        adcfg_pkg::ADDR_RANGE_ENHANCER:  next_st.enh     = req.wdata;
        adcfg_pkg::ADDR_GAIN_CONTROLLER: next_st.gc      = req.wdata;
        adcfg_pkg::ADDR_INPUT_ENABLE:    next_st.in_en   = req.wdata;
        adcfg_pkg::ADDR_OUTPUT_SLOT:     next_st.slot_en = req.wdata;
        adcfg_pkg::ADDR_POWER_CONFIG:    next_st.pwr     = req.wdata;
        default: ;
      endcase
    end

    // register reads answer one cycle later; volume reads wait for the memory
    next_st.rsp.rvalid = 1'b0;
    next_st.rd_mem     = 1'b0;
    if (st.rd_mem) begin
      next_st.rsp.rdata  = mem_rdata;
      next_st.rsp.rvalid = 1'b1;
    end else if (req.rd) begin
      unique case (req.addr)
        adcfg_pkg::ADDR_DSP_CONFIG_1:    next_st.rsp.rdata = st.dsp;
        adcfg_pkg::ADDR_RANGE_ENHANCER:  next_st.rsp.rdata = st.enh;
        adcfg_pkg::ADDR_GAIN_CONTROLLER: next_st.rsp.rdata = st.gc;
        adcfg_pkg::ADDR_INPUT_ENABLE:    next_st.rsp.rdata = st.in_en;
        adcfg_pkg::ADDR_OUTPUT_SLOT:     next_st.rsp.rdata = st.slot_en;
        adcfg_pkg::ADDR_POWER_CONFIG:    next_st.rsp.rdata = st.pwr;
        default:                         next_st.rsp.rdata = 8'h00;
      endcase
      next_st.rd_mem     = rhit;
      next_st.rsp.rvalid = !rhit;
    end

    // pdm-only channels cannot run without a microphone present
    next_st.ch_active  = st.in_en & (~adcfg_pkg::MASK_PDM_ONLY | pdm_sync);
    next_st.slot_drive = st.slot_en;
    next_st.ch_power   = st.pwr[adcfg_pkg::POS_CONVERTER_POWER] ?
                         next_st.ch_active : 8'h00;
    next_st.enh_act    = !st.dsp.enhancer_or_gainctl_select;
    next_st.gc_act     = st.dsp.enhancer_or_gainctl_select;
    next_st.reserved   = (st.enh.enhancer_threshold > adcfg_pkg::ENH_THRESH_MAX) ||
                         (st.enh.enhancer_gain_limit > adcfg_pkg::ENH_LIMIT_MAX) ||
                         (st.gc.gainctl_gain_limit > adcfg_pkg::GAINCTL_LIMIT_MAX);

    // applied volume walks channels; gang substitutes channel 1's code
    tgt = st.dsp.volume_gang ? mem_first : volume_target_at_unity;
    if (!st.ch_power[3'(adcfg_pkg::NUM_CHANNELS - 1) - st.vch]) begin
      tgt = adcfg_pkg::VOLUME_MUTE;
    end
    unique case (st.vstate)
      ST_IDLE: begin
        next_st.settled = (st.vcur == tgt);
        if (st.vcur != tgt) begin
          next_st.vstate = st.dsp.soft_step_disable ? ST_SNAP : ST_RAMP;
        end else begin
          next_st.vch = st.vch + 3'h1;
        end
      end
      ST_RAMP: begin
        next_st.vcur    = step_toward(st.vcur, tgt);
        next_st.settled = 1'b0;
        if (next_st.vcur == tgt) begin
          next_st.vstate = ST_IDLE;
        end
      end
      ST_SNAP: begin
        next_st.vcur    = tgt;
        next_st.settled = 1'b0;
        next_st.vstate  = ST_IDLE;
      end
      default: next_st.vstate = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st         <= '0;
      st.dsp     <= adcfg_pkg::RST_DSP_CONFIG_1;
      st.enh     <= adcfg_pkg::RST_RANGE_ENHANCER;
      st.gc      <= adcfg_pkg::RST_GAIN_CONTROLLER;
      st.in_en   <= adcfg_pkg::RST_INPUT_ENABLE;
      st.slot_en <= adcfg_pkg::RST_OUTPUT_SLOT;
      st.pwr     <= adcfg_pkg::RST_POWER_CONFIG;
      st.enh_act <= 1'b1;
      st.vstate  <= ST_IDLE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rsp                    = st.rsp;
  assign dsp_config             = st.dsp;
  assign enhancer_config        = st.enh;
  assign gainctl_config         = st.gc;
  assign channel_active         = st.ch_active;
  assign slot_drive             = st.slot_drive;
  assign channel_power          = st.ch_power;
  assign enhancer_active        = st.enh_act;
  assign gainctl_active         = st.gc_act;
  assign applied_volume         = st.vcur;
  assign applied_volume_channel = st.vch;
  assign volume_settled         = st.settled;
  assign code_reserved          = st.reserved;

endmodule

// >>> adcfg_pkg.sv
package adcfg_pkg;

  localparam logic [7:0] ADDR_DSP_CONFIG_1      = 8'h6c;
  localparam logic [7:0] ADDR_RANGE_ENHANCER    = 8'h6d;
  localparam logic [7:0] ADDR_GAIN_CONTROLLER   = 8'h70;
  localparam logic [7:0] ADDR_INPUT_ENABLE      = 8'h73;
  localparam logic [7:0] ADDR_OUTPUT_SLOT       = 8'h74;
  localparam logic [7:0] ADDR_POWER_CONFIG      = 8'h75;
  localparam logic [7:0] ADDR_CHANNEL_VOLUME    = 8'h3e;
  localparam int unsigned VOLUME_STRIDE         = 5;

  localparam logic [7:0] RST_DSP_CONFIG_1       = 8'h40;
  localparam logic [7:0] RST_RANGE_ENHANCER     = 8'h7b;
  localparam logic [7:0] RST_GAIN_CONTROLLER    = 8'he7;
  localparam logic [7:0] RST_INPUT_ENABLE       = 8'hf0;
  localparam logic [7:0] RST_OUTPUT_SLOT        = 8'h00;
  localparam logic [7:0] RST_POWER_CONFIG       = 8'h00;
  localparam logic [7:0] RST_CHANNEL_VOLUME     = 8'hc9;

  localparam int unsigned NUM_CHANNELS          = 8;
  localparam int unsigned POS_CONVERTER_POWER   = 6;
  localparam logic [7:0] MASK_PDM_ONLY          = 8'h0f;
  localparam logic [7:0] VOLUME_MUTE            = 8'h00;
  localparam logic [7:0] VOLUME_STEP            = 8'h01;
  localparam logic [3:0] ENH_THRESH_MAX         = 4'h9;
  localparam logic [3:0] ENH_LIMIT_MAX          = 4'hc;
  localparam logic [3:0] GAINCTL_LIMIT_MAX      = 4'hd;

  typedef struct packed {
    logic       volume_gang;
    logic [1:0] biquad_count;
    logic       soft_step_disable;
    logic       enhancer_or_gainctl_select;
    logic [2:0] spare;
  } adcfg_dsp1_t;

  typedef struct packed {
    logic [3:0] enhancer_threshold;
    logic [3:0] enhancer_gain_limit;
  } adcfg_enh_t;

  typedef struct packed {
    logic [3:0] gainctl_target;
    logic [3:0] gainctl_gain_limit;
  } adcfg_gainctl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcfg_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } adcfg_rsp_t;

endpackage

// >>> adcfg_volume_mem.sv
`timescale 1ns/1ps

module adcfg_volume_mem (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       wr,
  input  wire logic [2:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [2:0] raddr,
  output logic      [7:0] rdata,
  output logic      [7:0] first
);
  typedef struct packed {
    logic [7:0][7:0] vol;
    logic [7:0]      rdata;
  } adcfg_mem_state_t;

  adcfg_mem_state_t st;
  adcfg_mem_state_t next_st;

  always_comb begin
    next_st = st;
    if (wr) begin
      next_st.vol[waddr] = wdata;
    end
    next_st.rdata = st.vol[raddr];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st.vol   <= {8{adcfg_pkg::RST_CHANNEL_VOLUME}};
      st.rdata <= adcfg_pkg::RST_CHANNEL_VOLUME;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign first = st.vol[0];
endmodule

// >>> adcfg_host.sv
`timescale 1ns/1ps

// host side of the register port: one-byte strobes, answer waited for under a bound
module adcfg_host (
  input  wire adcfg_pkg::adcfg_rsp_t rsp,
  input  wire logic                  mclk,
  output adcfg_pkg::adcfg_req_t      req
);
  initial req = '0;

  // strobe is left high so writes may follow back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
  endtask

  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    req.rd <= 1'b0;
    ok = 1'b0;
    d = 8'h00;
    // answer is taken at the edge where rvalid is sampled high
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge mclk);
      ok = rsp.rvalid;
      d = rsp.rdata;
    end
  endtask
endmodule

// >>> adcfg_bank_assertions.sv
`timescale 1ns/1ps

module adcfg_bank_chk (
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic                      ce,
  input wire adcfg_pkg::adcfg_req_t     req,
  input wire adcfg_pkg::adcfg_rsp_t     rsp,
  input wire logic [7:0]                pdm_present,
  input wire adcfg_pkg::adcfg_dsp1_t    dsp_config,
  input wire adcfg_pkg::adcfg_enh_t     enhancer_config,
  input wire adcfg_pkg::adcfg_gainctl_t gainctl_config,
  input wire logic [7:0]                channel_active,
  input wire logic [7:0]                slot_drive,
  input wire logic [7:0]                channel_power,
  input wire logic                      enhancer_active,
  input wire logic                      gainctl_active,
  input wire logic                      code_reserved
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  rd_answer_a: assert property (ce && req.rd && req.addr inside {[8'h6c:8'h75]}
    |=> rsp.rvalid) else $error("read not answered");
  rvalid_cause_a: assert property (rsp.rvalid |-> $past(req.rd) || $past(req.rd, 2))
    else $error("answer without read");
  reset_vals_a: assert property ($fell(rst) |-> dsp_config == 8'h40
    && enhancer_config == 8'h7b && gainctl_config == 8'he7) else $error("bad reset value");
  one_feature_a: assert property (enhancer_active != gainctl_active)
    else $error("feature select");
  select_follow_a: assert property ($rose(dsp_config.enhancer_or_gainctl_select)
    |-> ##[0:2] gainctl_active) else $error("select not followed");
  slot_follow_a: assert property (ce && req.wr && req.addr == 8'h74 ##1 ce
    |=> slot_drive == $past(req.wdata, 2)) else $error("slot drive");
  power_subset_a: assert property ((channel_power & ~channel_active) == 8'h00)
    else $error("power leak");
  power_off_a: assert property (ce && req.wr && req.addr == 8'h75 && !req.wdata[6] ##1 ce
    |=> channel_power == 8'h00) else $error("power not off");
  pdm_gate_a: assert property ((ce && pdm_present[3:0] == 4'h0) [*5]
    |-> channel_active[3:0] == 4'h0) else $error("pdm gate");
  reserved_flag_a: assert property (ce && req.wr && req.addr == 8'h6d
    && req.wdata[7:4] > 4'h9 |-> ##[1:3] code_reserved) else $error("reserved flag");
endmodule

bind adcfg_bank adcfg_bank_chk chk (.mclk, .rst, .ce, .req, .rsp, .pdm_present, .dsp_config,
  .enhancer_config, .gainctl_config, .channel_active, .slot_drive, .channel_power,
  .enhancer_active, .gainctl_active, .code_reserved);

// >>> tb_top.sv
`timescale 1ns/1ps

module tb_top;
  logic                      mclk = 1'b0;
  logic                      rst = 1'b1;
  logic                      ce = 1'b1;
  logic [7:0]                pdm_present = 8'h00;
  logic [7:0]                own_volume = 8'hc9;
  adcfg_pkg::adcfg_req_t     req;
  adcfg_pkg::adcfg_rsp_t     rsp;
  adcfg_pkg::adcfg_dsp1_t    dsp_config;
  adcfg_pkg::adcfg_enh_t     enhancer_config;
  adcfg_pkg::adcfg_gainctl_t gainctl_config;
  logic [7:0]                channel_active;
  logic [7:0]                slot_drive;
  logic [7:0]                channel_power;
  logic                      enhancer_active;
  logic                      gainctl_active;
  logic [7:0]                applied_volume;
  logic [2:0]                applied_volume_channel;
  logic                      volume_settled;
  logic                      code_reserved;
  int                        err_count = 0;
  int                        n_tests = 0;

  always #12.5 mclk = ~mclk;

  adcfg_host host (.rsp, .mclk, .req);
  adcfg_bank dut (.mclk, .rst, .ce, .req, .rsp, .pdm_present,
    .volume_target_at_unity(own_volume), .dsp_config, .enhancer_config, .gainctl_config,
    .channel_active, .slot_drive, .channel_power, .enhancer_active, .gainctl_active,
    .applied_volume, .applied_volume_channel, .volume_settled, .code_reserved);

  task automatic complete_run;
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    if (!ok) begin
      err_count++;
      complete_run;
    end else begin
      check(d, exp);
    end
  endtask

  task automatic look(input int n);
    host.idle(n);
  endtask

  // waits until the volume walk has settled the channel before next_ch; mid marks a
  // level strictly between mute and hi seen on the way
  task automatic vol_at(input logic [2:0] next_ch, input logic [7:0] hi,
                        output logic [7:0] v, output logic mid);
    v   = 8'h00;
    mid = 1'b0;
    for (int i = 0; i < 600; i++) begin
      @(posedge mclk);
      if (applied_volume > 8'h00 && applied_volume < hi) begin
        mid = 1'b1;
      end
      if (volume_settled === 1'b1 && applied_volume_channel === next_ch) begin
        v = applied_volume;
        return;
      end
    end
    err_count++;
    complete_run;
  endtask

  task automatic t_reset;
    rchk(8'h6c, 8'h40);
    rchk(8'h6d, 8'h7b);
    rchk(8'h70, 8'he7);
    rchk(8'h73, 8'hf0);
    rchk(8'h74, 8'h00);
    rchk(8'h75, 8'h00);
  endtask

  // back-to-back writes, unmapped place among them
  task automatic t_rw;
    host.wr(8'h6d, 8'h95);
    host.wr(8'h70, 8'h3c);
    host.wr(8'h71, 8'hff);
    host.wr(8'h74, 8'ha5);
    rchk(8'h6d, 8'h95);
    rchk(8'h70, 8'h3c);
    rchk(8'h71, 8'h00);
    rchk(8'h74, 8'ha5);
    check(slot_drive, 8'ha5);
    check(enhancer_config, 8'h95);
    check(gainctl_config, 8'h3c);
  endtask

  task automatic t_dsp;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {i[1], i[1:0], i[0], i[0], 3'b000};
      host.wr(8'h6c, v);
      rchk(8'h6c, v);
      check({6'h0, dsp_config.biquad_count}, {6'h0, i[1:0]});
      check({6'h0, gainctl_active, enhancer_active}, {6'h0, i[0], ~i[0]});
    end
  endtask

  task automatic resv(input logic [7:0] a, input logic [7:0] d, input logic e);
    host.wr(a, d);
    look(4);
    check({7'h0, code_reserved}, {7'h0, e});
  endtask

  task automatic t_power;
    host.wr(8'h73, 8'hff);
    host.wr(8'h75, 8'h40);
    look(6);
    check(channel_active, 8'hf0);
    check(channel_power, 8'hf0);
    pdm_present <= 8'h0a;
    look(6);
    check(channel_active, 8'hfa);
    check(channel_power, 8'hfa);
    host.wr(8'h73, 8'h5a);
    host.wr(8'h75, 8'h00);
    look(6);
    check(channel_active, 8'h5a);
    check(channel_power, 8'h00);
  endtask

  // channel 1 off, channels 2-4 powered: gang, own codes and stepping seen on the walk
  task automatic t_volume;
    logic [7:0] v;
    logic       mid;
    host.wr(8'h73, 8'h70);
    host.wr(8'h75, 8'h40);
    host.wr(8'h3e, 8'h10);
    host.wr(8'h6c, 8'h80);
    rchk(8'h3e, 8'h10);
    vol_at(3'h4, 8'h10, v, mid);
    vol_at(3'h4, 8'h10, v, mid);
    check(v, 8'h10);
    vol_at(3'h5, 8'h10, v, mid);
    check(v, 8'h00);
    check({7'h0, mid}, 8'h01);
    host.wr(8'h6c, 8'h90);
    look(1);
    vol_at(3'h4, 8'h10, v, mid);
    check(v, 8'h10);
    vol_at(3'h5, 8'h10, v, mid);
    check({7'h0, mid}, 8'h00);
    host.wr(8'h6c, 8'h00);
    own_volume <= 8'h08;
    look(1);
    vol_at(3'h4, 8'h10, v, mid);
    vol_at(3'h4, 8'h10, v, mid);
    check(v, 8'h08);
  endtask

  // frozen clock enable drops the write, then a mid-run reset restores the table
  task automatic t_freeze;
    ce <= 1'b0;
    host.wr(8'h74, 8'h3c);
    look(2);
    ce <= 1'b1;
    rchk(8'h74, 8'ha5);
    rst <= 1'b1;
    look(3);
    rst <= 1'b0;
    look(1);
    rchk(8'h6d, 8'h7b);
    rchk(8'h73, 8'hf0);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_rw;
    t_dsp;
    resv(8'h6d, 8'ha0, 1'b1);
    resv(8'h6d, 8'h0d, 1'b1);
    resv(8'h6d, 8'h9c, 1'b0);
    resv(8'h70, 8'hfe, 1'b1);
    resv(8'h70, 8'hfd, 1'b0);
    t_power;
    t_volume;
    t_freeze;
    complete_run;
  end
endmodule
